/* rtl/debug_perf_csrs.sv */
// Purpose: debug control, debug scratch and performance counter registers
// Assumes: register port strobes are on clk; core inputs are on clk
// Notes: unmapped and unimplemented addresses read zero, writes dropped

`timescale 1ns/1ps
`default_nettype none

// Contract
// - debug control bits 31:28 always read 4 and ignore writes.
// - supervisor and user breakpoint bits 13:12 and privilege field are legal-only, bits 13:12 read 0.
// - debug control bits 1:0 always read 3 for machine mode.
// - on debug entry the return address takes the next instruction address.
// - two 32-bit scratch registers at 0x7B2 and 0x7B3, read/write, reset 0.
// - inhibit bit 0 freezes cycles, bit 2 retired, bit 3 first event, bit 1 reads 0, all set at reset.
// - inhibit bits of unimplemented event counters read 0.
// - event selectors from 0x323 hold a 16-bit mask, upper bits read 0.
// - 64-bit cycle counter, low half at 0xB00, high half at 0xB80.
// - 64-bit retired counter, low half at 0xB02, high half at 0xB82.
// - event counter quantity is a parameter 0 to 29, default 1.
// - event counters are 64 bits, low halves from 0xB03, high halves from 0xB83.
// - selectors and counters of unimplemented slots read 0.
// - read-only copies of the low halves at 0xC00, 0xC02 and from 0xC03.
// - read-only copies of the high halves at 0xC80, 0xC82 and from 0xC83.
module debug_perf_csrs #(
  parameter int event_counter_quantity = perf_debug_pkg::EVT_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [perf_debug_pkg::ADDR_W-1:0] addr,
  input wire logic [perf_debug_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic retire,
  input wire logic [perf_debug_pkg::SEL_W-1:0] event_in,
  input wire logic debug_entry,
  input wire logic [31:0] debug_next_pc,
  input wire logic [perf_debug_pkg::CAUSE_W-1:0] debug_cause,
  output logic [perf_debug_pkg::DATA_W-1:0] rdata_q,
  output logic ebreakm_q,
  output logic stepie_q,
  output logic step_q
);
  import perf_debug_pkg::*;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // true when the address falls in the slot range of a 32-entry bank
  function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base);
    return (a[11:5] == base[11:5]) && (a[4:0] >= base[4:0]);
  endfunction

  // inhibit bits that exist for this counter quantity
  function automatic logic [31:0] impl_mask(input int n);
    logic [31:0] m;
    m = 32'h0;
    m[CYC_INH_BIT] = 1'b1;
    m[RET_INH_BIT] = 1'b1;
    for (int i = 0; i < n; i++) begin
      m[EVT_INH_BIT0 + i] = 1'b1;
    end
    return m;
  endfunction

  localparam logic [31:0] INH_MASK = impl_mask(event_counter_quantity);
  localparam logic [4:0] EVT_N = 5'(event_counter_quantity);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [31:0] inhibit_q;
  logic [31:0] dpc_q;
  logic [31:0] scratch0_q;
  logic [31:0] scratch1_q;
  logic [CAUSE_W-1:0] cause_q;
  logic [63:0] cyc_cnt;
  logic [63:0] ret_cnt;
  logic [63:0] evt_cnt [MAX_EVT];
  logic [SEL_W-1:0] sel_q [MAX_EVT];

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire wr_en = clk_en && wr;
  wire rd_en = clk_en && rd;
  wire [4:0] slot = addr[4:0] - EVT_SLOT_FIRST;
  wire slot_ok = slot < EVT_N;
  wire [4:0] sidx = slot_ok ? slot : 5'h00;
  wire hit_sel = in_bank(addr, A_SEL_BASE) && slot_ok;
  wire hit_evt_lo = in_bank(addr, A_EVT_LO) && slot_ok;
  wire hit_evt_hi = in_bank(addr, A_EVT_HI) && slot_ok;
  wire hit_uevt_lo = in_bank(addr, A_UEVT_LO) && slot_ok;
  wire hit_uevt_hi = in_bank(addr, A_UEVT_HI) && slot_ok;
  wire wr_cyc_lo = wr_en && addr == A_CYC_LO;
  wire wr_cyc_hi = wr_en && addr == A_CYC_HI;
  wire wr_ret_lo = wr_en && addr == A_RET_LO;
  wire wr_ret_hi = wr_en && addr == A_RET_HI;

  // fields 13:12 and the privilege field are never stored: writes settle at legal values
  wire [31:0] dcsr_word = {DEBUG_VERSION, 12'h000, ebreakm_q, 3'b000,
                           stepie_q, 2'b00, cause_q, 3'b000, step_q,
                           PRIV_MACHINE};

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  wire [31:0] rd_word =
    (addr == A_INHIBIT) ? inhibit_q :
    (addr == A_DCSR) ? dcsr_word :
    (addr == A_DPC) ? dpc_q :
    (addr == A_SCR0) ? scratch0_q :
    (addr == A_SCR1) ? scratch1_q :
    (addr == A_CYC_LO || addr == A_UCYC_LO) ? cyc_cnt[31:0] :
    (addr == A_CYC_HI || addr == A_UCYC_HI) ? cyc_cnt[63:32] :
    (addr == A_RET_LO || addr == A_URET_LO) ? ret_cnt[31:0] :
    (addr == A_RET_HI || addr == A_URET_HI) ? ret_cnt[63:32] :
    hit_sel ? {16'h0000, sel_q[sidx]} :
    (hit_evt_lo || hit_uevt_lo) ? evt_cnt[sidx][31:0] :
    (hit_evt_hi || hit_uevt_hi) ? evt_cnt[sidx][63:32] :
    32'h0000_0000;

  // read data stands after the strobe until the next clk_en edge without rd
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata_q <= rd ? rd_word : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // debug registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ebreakm_q <= DCSR_RESET[EBREAKM_BIT];
      stepie_q <= DCSR_RESET[STEPIE_BIT];
      step_q <= DCSR_RESET[STEP_BIT];
      cause_q <= DCSR_RESET[CAUSE_LSB +: CAUSE_W];
    end else if (clk_en) begin
      if (wr && addr == A_DCSR) begin
        ebreakm_q <= wdata[EBREAKM_BIT];
        stepie_q <= wdata[STEPIE_BIT];
        step_q <= wdata[STEP_BIT];
      end
      // only debug entry loads the cause; software writes leave it
      if (debug_entry) begin
        cause_q <= debug_cause;
      end
    end
  end

  // return address is read-only to software; only debug entry loads it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dpc_q <= 32'h0000_0000;
    end else if (clk_en && debug_entry) begin
      dpc_q <= debug_next_pc;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scratch0_q <= 32'h0000_0000;
      scratch1_q <= 32'h0000_0000;
    end else if (wr_en) begin
      if (addr == A_SCR0) begin
        scratch0_q <= wdata;
      end
      if (addr == A_SCR1) begin
        scratch1_q <= wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // counter inhibit
  // ------------------------------------------------------------
  // counting starts disabled; missing counters keep their bits at zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inhibit_q <= INH_MASK;
    end else if (wr_en && addr == A_INHIBIT) begin
      inhibit_q <= wdata & INH_MASK;
    end
  end

  // ------------------------------------------------------------
  // fixed counters
  // ------------------------------------------------------------
  perf_counter64 u_cycles (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .inc(!inhibit_q[CYC_INH_BIT]),
    .wr_lo(wr_cyc_lo),
    .wr_hi(wr_cyc_hi),
    .wdata(wdata),
    .count_q(cyc_cnt)
  );

  perf_counter64 u_retired (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .inc(retire && !inhibit_q[RET_INH_BIT]),
    .wr_lo(wr_ret_lo),
    .wr_hi(wr_ret_hi),
    .wdata(wdata),
    .count_q(ret_cnt)
  );

  // ------------------------------------------------------------
  // event counters and selectors
  // ------------------------------------------------------------
  for (genvar i = 0; i < MAX_EVT; i++) begin : g_evt
    if (i < event_counter_quantity) begin : g_on
      wire mine = slot_ok && sidx == 5'(i);
      // counts one per cycle in which any selected event is active
      wire hit = |(sel_q[i] & event_in);

      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          sel_q[i] <= 16'h0000;
        end else if (wr_en && mine && in_bank(addr, A_SEL_BASE)) begin
          sel_q[i] <= wdata[SEL_W-1:0];
        end
      end

      perf_counter64 u_evt (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .inc(hit && !inhibit_q[EVT_INH_BIT0 + i]),
        .wr_lo(wr_en && mine && in_bank(addr, A_EVT_LO)),
        .wr_hi(wr_en && mine && in_bank(addr, A_EVT_HI)),
        .wdata(wdata),
        .count_q(evt_cnt[i])
      );
    end else begin : g_off
      assign sel_q[i] = 16'h0000;
      assign evt_cnt[i] = 64'h0;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_dcsr_fixed;
    rd_en && addr == A_DCSR |=> rdata_q[31:28] == 4'h4;
  endproperty
  a_dcsr_fixed: assert property (p_dcsr_fixed) else $error("debug version wrong");

  property p_dcsr_bkpt;
    rd_en && addr == A_DCSR |=> rdata_q[13:12] == 2'b00;
  endproperty
  a_dcsr_bkpt: assert property (p_dcsr_bkpt) else $error("breakpoint bits set");

  property p_dcsr_prv;
    rd_en && addr == A_DCSR |=> rdata_q[1:0] == 2'h3;
  endproperty
  a_dcsr_prv: assert property (p_dcsr_prv) else $error("privilege not machine");

  property p_dpc_load;
    clk_en && debug_entry |=> dpc_q == $past(debug_next_pc);
  endproperty
  a_dpc_load: assert property (p_dpc_load) else $error("return address not loaded");

  property p_scratch;
    wr_en && addr == A_SCR1 |=> scratch1_q == $past(wdata);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch lost");

  property p_inh_freeze;
    clk_en && inhibit_q[RET_INH_BIT] && !wr_ret_lo && !wr_ret_hi |=> $stable(ret_cnt);
  endproperty
  a_inh_freeze: assert property (p_inh_freeze) else $error("inhibited counter moved");

  property p_inh_mask;
    rd_en && addr == A_INHIBIT |=> (rdata_q & ~INH_MASK) == 32'h0000_0000;
  endproperty
  a_inh_mask: assert property (p_inh_mask) else $error("unimplemented inhibit set");

  property p_sel_upper;
    rd_en && in_bank(addr, A_SEL_BASE) |=> rdata_q[31:16] == 16'h0000;
  endproperty
  a_sel_upper: assert property (p_sel_upper) else $error("selector upper bits set");

  property p_cyc_count;
    clk_en && !inhibit_q[CYC_INH_BIT] && !wr_cyc_lo && !wr_cyc_hi
      |=> cyc_cnt == $past(cyc_cnt) + 64'h1;
  endproperty
  a_cyc_count: assert property (p_cyc_count) else $error("cycle counter missed");

  property p_unimpl_zero;
    rd_en && in_bank(addr, A_EVT_HI) && !slot_ok |=> rdata_q == 32'h0000_0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("missing counter nonzero");

  property p_copy_hi;
    rd_en && addr == A_URET_HI |=> rdata_q == $past(ret_cnt[63:32]);
  endproperty
  a_copy_hi: assert property (p_copy_hi) else $error("retired copy differs");

  property p_copy_lo;
    rd_en && addr == A_UCYC_LO |=> rdata_q == $past(cyc_cnt[31:0]);
  endproperty
  a_copy_lo: assert property (p_copy_lo) else $error("cycle copy differs");
endmodule

`default_nettype wire

/* rtl/perf_debug_pkg.sv */
// Purpose: shared constants for the debug and performance counter registers
// Assumes: 12-bit register address space, 32-bit data
// Notes: bank offsets are the first implemented slot of each bank

package perf_debug_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam logic [11:0] A_INHIBIT = 12'h320;
  localparam logic [11:0] A_SEL_BASE = 12'h323;
  localparam logic [11:0] A_DCSR = 12'h7B0;
  localparam logic [11:0] A_DPC = 12'h7B1;
  localparam logic [11:0] A_SCR0 = 12'h7B2;
  localparam logic [11:0] A_SCR1 = 12'h7B3;
  localparam logic [11:0] A_CYC_LO = 12'hB00;
  localparam logic [11:0] A_RET_LO = 12'hB02;
  localparam logic [11:0] A_EVT_LO = 12'hB03;
  localparam logic [11:0] A_CYC_HI = 12'hB80;
  localparam logic [11:0] A_RET_HI = 12'hB82;
  localparam logic [11:0] A_EVT_HI = 12'hB83;
  localparam logic [11:0] A_UCYC_LO = 12'hC00;
  localparam logic [11:0] A_URET_LO = 12'hC02;
  localparam logic [11:0] A_UEVT_LO = 12'hC03;
  localparam logic [11:0] A_UCYC_HI = 12'hC80;
  localparam logic [11:0] A_URET_HI = 12'hC82;
  localparam logic [11:0] A_UEVT_HI = 12'hC83;
  // ------------------------------------------------------------
  // debug control fields
  // ------------------------------------------------------------
  localparam logic [3:0] DEBUG_VERSION = 4'h4;
  localparam logic [1:0] PRIV_MACHINE = 2'h3;
  localparam int EBREAKM_BIT = 15;
  localparam int STEPIE_BIT = 11;
  localparam int STEP_BIT = 2;
  localparam int CAUSE_LSB = 6;
  localparam int CAUSE_W = 3;
  localparam logic [31:0] DCSR_RESET = 32'h4000_0003;
  // ------------------------------------------------------------
  // counters
  // ------------------------------------------------------------
  localparam logic [31:0] INHIBIT_RESET = 32'h0000_000D;
  localparam int CYC_INH_BIT = 0;
  localparam int RET_INH_BIT = 2;
  localparam int EVT_INH_BIT0 = 3;
  localparam logic [4:0] EVT_SLOT_FIRST = 5'h03;
  localparam int SEL_W = 16;
  localparam int MAX_EVT = 29;
  localparam int EVT_DEFAULT = 1;
  localparam logic [63:0] CNT_RESET = 64'h0;
endpackage

/* rtl/perf_counter64.sv */
// Purpose: one 64-bit counter with separately writable halves
// Assumes: write and increment in one cycle: the write wins
// Notes: frozen while clk_en is low

`timescale 1ns/1ps
`default_nettype none

module perf_counter64 (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic inc,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [31:0] wdata,
  output logic [63:0] count_q
);
  import perf_debug_pkg::*;

  logic [63:0] count_d;

  // carry from the low half reaches the high half in the same add
  assign count_d = wr_lo ? {count_q[63:32], wdata} :
                   wr_hi ? {wdata, count_q[31:0]} :
                   inc ? count_q + 64'h1 : count_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= CNT_RESET;
    end else if (clk_en) begin
      count_q <= count_d;
    end
  end

  property p_write_wins;
    @(posedge clk) disable iff (!resetn)
    clk_en && wr_lo |=> count_q[31:0] == $past(wdata);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("low half write lost");
endmodule

`default_nettype wire

/* bench/tb_top.sv */
// Purpose: self-checking bench for the debug and counter registers
// Assumes: one access per two cycles; counting windows are counted in edges
// Notes: expected values come from the register table

`timescale 1ns/1ps
`default_nettype none

`define CHECK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module tb_top;
  import perf_debug_pkg::*;
  localparam logic [11:0] zero_at_reset [15] = '{A_DPC, A_SCR0, A_SCR1, A_SEL_BASE,
    A_CYC_LO, A_CYC_HI, A_RET_LO, A_RET_HI, A_EVT_LO, A_EVT_HI, A_UCYC_LO,
    A_UCYC_HI, A_URET_LO, A_URET_HI, A_UEVT_HI};
  localparam logic [31:0] dcsr_bits [3] = '{32'h0000_8000, 32'h0000_0800, 32'h0000_0004};
  localparam logic [15:0] ev_seq [4] = '{16'h0002, 16'h0004, 16'h0005, 16'hFFFA};
  logic clk;
  logic resetn;
  logic clk_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic retire;
  logic [SEL_W-1:0] event_in;
  logic debug_entry;
  logic [31:0] debug_next_pc;
  logic [CAUSE_W-1:0] debug_cause;
  logic [DATA_W-1:0] rdata_q;
  logic ebreakm_q;
  logic stepie_q;
  logic step_q;
  int fail_count;
  int tests_run;

  debug_perf_csrs #(.event_counter_quantity(1)) u_dut (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .retire(retire),
    .event_in(event_in),
    .debug_entry(debug_entry),
    .debug_next_pc(debug_next_pc),
    .debug_cause(debug_cause),
    .rdata_q(rdata_q),
    .ebreakm_q(ebreakm_q),
    .stepie_q(stepie_q),
    .step_q(step_q)
  );

  // ------------------------------------------------------------
  // clock and access tasks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // strobe dropped one edge before the next access, so no double drive
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHECK(rdata_q, exp)
    @(posedge clk);
  endtask

  task automatic end_of_test();
    $display("TB: %0d checks, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    fail_count = 0;
    tests_run = 0;
    resetn = 1'b0;
    clk_en = 1'b1;
    addr = 12'h000;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    retire = 1'b0;
    event_in = 16'h0000;
    debug_entry = 1'b0;
    debug_next_pc = 32'h0000_0000;
    debug_cause = 3'h0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // reset values; counters must stay frozen while inhibited
    rd_reg(A_DCSR, 32'h4000_0003);
    rd_reg(A_INHIBIT, 32'h0000_000D);
    foreach (zero_at_reset[i]) rd_reg(zero_at_reset[i], 32'h0000_0000);
    #1;
    `CHECK(rdata_q, 32'h0000_0000)
    @(posedge clk);
    // debug control: fixed fields survive every write
    wr_reg(A_DCSR, 32'hFFFF_FFFF);
    rd_reg(A_DCSR, 32'h4000_8807);
    for (int i = 0; i < 3; i++) begin
      wr_reg(A_DCSR, dcsr_bits[i]);
      rd_reg(A_DCSR, 32'h4000_0003 | dcsr_bits[i]);
      `CHECK({ebreakm_q, stepie_q, step_q}, 3'b100 >> i)
    end
    // debug entry; return address is not software writable
    debug_next_pc <= 32'h8000_1235;
    debug_cause <= 3'h5;
    debug_entry <= 1'b1;
    @(posedge clk);
    debug_entry <= 1'b0;
    debug_next_pc <= 32'h7FFF_EDCA;
    debug_cause <= 3'h2;
    @(posedge clk);
    wr_reg(A_DPC, 32'h0000_0000);
    rd_reg(A_DPC, 32'h8000_1235);
    rd_reg(A_DCSR, 32'h4000_0147);
    // scratches are independent; a frozen clock enable drops the write
    wr_reg(A_SCR0, 32'hA5A5_5A5A);
    wr_reg(A_SCR1, 32'h0F0F_F0F0);
    clk_en <= 1'b0;
    wr_reg(A_SCR0, 32'hDEAD_BEEF);
    clk_en <= 1'b1;
    rd_reg(A_SCR0, 32'hA5A5_5A5A);
    rd_reg(A_SCR1, 32'h0F0F_F0F0);
    // masked fields, unimplemented slots, unmapped places
    wr_reg(A_INHIBIT, 32'hFFFF_FFFF);
    rd_reg(A_INHIBIT, 32'h0000_000D);
    wr_reg(A_SEL_BASE, 32'hFFFF_FFFF);
    rd_reg(A_SEL_BASE, 32'h0000_FFFF);
    wr_reg(A_SEL_BASE + 12'h001, 32'hFFFF_FFFF);
    rd_reg(A_SEL_BASE + 12'h001, 32'h0000_0000);
    wr_reg(A_EVT_LO + 12'h001, 32'h0000_0001);
    rd_reg(A_EVT_LO + 12'h001, 32'h0000_0000);
    rd_reg(A_UEVT_HI + 12'h001, 32'h0000_0000);
    rd_reg(A_EVT_HI + 12'h001, 32'h0000_0000);
    wr_reg(12'h7B4, 32'hFFFF_FFFF);
    rd_reg(12'h7B4, 32'h0000_0000);
    // cycle counter: 32 counted edges across the low-half carry
    wr_reg(A_CYC_LO, 32'hFFFF_FFF0);
    wr_reg(A_CYC_HI, 32'h0000_0005);
    wr_reg(A_UCYC_LO, 32'h0000_0000);
    rd_reg(A_CYC_LO, 32'hFFFF_FFF0);
    wr_reg(A_INHIBIT, 32'h0000_000C);
    repeat (30) @(posedge clk);
    wr_reg(A_INHIBIT, 32'h0000_000D);
    rd_reg(A_CYC_LO, 32'h0000_0010);
    rd_reg(A_CYC_HI, 32'h0000_0006);
    rd_reg(A_UCYC_LO, 32'h0000_0010);
    rd_reg(A_UCYC_HI, 32'h0000_0006);
    // retired counter: first retire edge still inhibited, then five count
    wr_reg(A_RET_LO, 32'hFFFF_FFFE);
    retire <= 1'b1;
    wr_reg(A_INHIBIT, 32'h0000_0009);
    repeat (4) @(posedge clk);
    retire <= 1'b0;
    wr_reg(A_INHIBIT, 32'h0000_000D);
    rd_reg(A_RET_LO, 32'h0000_0003);
    rd_reg(A_RET_HI, 32'h0000_0001);
    rd_reg(A_URET_LO, 32'h0000_0003);
    rd_reg(A_URET_HI, 32'h0000_0001);
    rd_reg(A_CYC_LO, 32'h0000_0010);
    // event counter: only selected events count, once per cycle
    wr_reg(A_EVT_HI, 32'h0000_0007);
    wr_reg(A_SEL_BASE, 32'h0000_0005);
    wr_reg(A_INHIBIT, 32'h0000_0005);
    for (int i = 0; i < 4; i++) begin
      event_in <= ev_seq[i];
      @(posedge clk);
    end
    event_in <= 16'h0000;
    wr_reg(A_INHIBIT, 32'h0000_000D);
    rd_reg(A_EVT_LO, 32'h0000_0002);
    rd_reg(A_EVT_HI, 32'h0000_0007);
    rd_reg(A_UEVT_LO, 32'h0000_0002);
    rd_reg(A_UEVT_HI, 32'h0000_0007);
    // second reset in mid-run
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd_reg(A_DCSR, 32'h4000_0003);
    rd_reg(A_SCR0, 32'h0000_0000);
    rd_reg(A_INHIBIT, 32'h0000_000D);
    rd_reg(A_CYC_HI, 32'h0000_0000);
    end_of_test();
  end
endmodule

`default_nettype wire
